/* File: src/event_timer_defs.svh */
// Offsets, field positions, legacy line numbers and sizes of the event timer block
`ifndef EVENT_TIMER_DEFS_SVH
`define EVENT_TIMER_DEFS_SVH
`define ET_MAX_TIMERS      8
`define ET_ADDR_W          12
`define ET_LINES           32
`define ET_GEN_CFG         12'h010
`define ET_INT_STATUS      12'h020
`define ET_INT_CLEAR       12'h024
`define ET_INT_ENABLE      12'h028
`define ET_COUNT_LO        12'h0F0
`define ET_COUNT_HI        12'h0F4
`define ET_TMR_BASE_SEL    4'h1
`define ET_TMR_CFG         5'h00
`define ET_TMR_CMP_LO      5'h08
`define ET_TMR_CMP_HI      5'h0C
`define ET_GEN_EN_BIT      0
`define ET_GEN_LEGACY_BIT  1
`define ET_CFG_LEVEL_BIT   1
`define ET_CFG_INTEN_BIT   2
`define ET_CFG_PERIOD_BIT  3
`define ET_CFG_PERCAP_BIT  4
`define ET_CFG_SIZECAP_BIT 5
`define ET_CFG_LOAD_BIT    6
`define ET_CFG_WIDE_BIT    8
`define ET_CFG_ROUTE_LSB   9
`define ET_LEGACY_LINE0    5'h00
`define ET_LEGACY_LINE1    5'h08
`endif

/* File: src/event_timer_pkg.sv */
// Types of the event timer block
`include "event_timer_defs.svh"
package event_timer_pkg;
  typedef struct packed {
    logic       int_en;
    logic       level;
    logic       periodic;
    logic       direct_load;
    logic       wide;
    logic [4:0] route;
  } timer_cfg_s;

  typedef struct packed {
    logic                                 en;
    logic                                 legacy;
    logic [63:0]                          count;
    logic [63:0]                          period;
    logic [`ET_MAX_TIMERS-1:0][63:0]      cmp;
    timer_cfg_s [`ET_MAX_TIMERS-1:0]      cfg;
    logic [`ET_MAX_TIMERS-1:0]            status;
    logic [`ET_MAX_TIMERS-1:0]            irq_en;
    logic [`ET_MAX_TIMERS-1:0]            pulse;
    logic [31:0]                          rd_data;
  } timer_state_s;
endpackage

/* File: src/periodic_event_timer_comparator.sv */
// Main counter, comparators, periodic advance and interrupt routing
`timescale 1ns/1ps
`include "event_timer_defs.svh"
module periodic_event_timer_comparator
  import event_timer_pkg::*;
#(
  parameter int NUM_TIMERS = `ET_MAX_TIMERS
)(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [`ET_ADDR_W-1:0] addr,
  input  wire logic [31:0]           wr_data,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic [31:0]                rd_data,
  output logic                       irq,
  output logic [`ET_LINES-1:0]       irq_lines
);
  // Refuse timer counts that the state struct cannot hold
  if (NUM_TIMERS < 1 || NUM_TIMERS > `ET_MAX_TIMERS)
  begin : g_bad_timers
    $error("NUM_TIMERS out of range");
  end

  timer_state_s              st;
  timer_state_s              next_st;
  logic [`ET_MAX_TIMERS-1:0] match;
  logic [`ET_MAX_TIMERS-1:0] cmp_lo_wr;
  logic [`ET_MAX_TIMERS-1:0] cmp_hi_wr;
  logic                      cnt_wr;

  // Per-timer register hit: returns one when addr names timer t, register r
  function automatic logic tmr_hit(input logic [`ET_ADDR_W-1:0] a, input int t,
                                   input logic [4:0] r);
    tmr_hit = (a[11:8] == `ET_TMR_BASE_SEL) && (a[7:5] == 3'(t)) && (a[4:0] == r);
  endfunction

  function automatic logic [31:0] cfg_word(input timer_cfg_s c, input int t);
    cfg_word = 32'h0000_0000;
    cfg_word[`ET_CFG_LEVEL_BIT]   = c.level;
    cfg_word[`ET_CFG_INTEN_BIT]   = c.int_en;
    cfg_word[`ET_CFG_PERIOD_BIT]  = c.periodic;
    cfg_word[`ET_CFG_PERCAP_BIT]  = (t == 0);
    cfg_word[`ET_CFG_SIZECAP_BIT] = (t == 0);
    cfg_word[`ET_CFG_LOAD_BIT]    = c.direct_load;
    cfg_word[`ET_CFG_WIDE_BIT]    = c.wide;
    cfg_word[`ET_CFG_ROUTE_LSB+:5] = c.route;
  endfunction

  always_comb
  begin
    cnt_wr = wr_en && (addr == `ET_COUNT_LO || addr == `ET_COUNT_HI);
    for (int i = 0; i < `ET_MAX_TIMERS; i++)
    begin
      cmp_lo_wr[i] = wr_en && (i < NUM_TIMERS) && tmr_hit(addr, i, `ET_TMR_CMP_LO);
      cmp_hi_wr[i] = wr_en && (i == 0) && tmr_hit(addr, i, `ET_TMR_CMP_HI);
      // Wide compare only for timer zero in 64-bit mode
      if (i < NUM_TIMERS)
        match[i] = st.en && ((i == 0 && st.cfg[i].wide) ? (st.count == st.cmp[i]) :
                   (st.count[31:0] == st.cmp[i][31:0]));
      else
        match[i] = 1'b0;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.pulse = '0;
    next_st.rd_data = 32'h0000_0000;
    if (st.en && !cnt_wr)
      next_st.count = st.count + 64'h1;
    if (wr_en)
    begin
      if (addr == `ET_GEN_CFG)
      begin
        next_st.en     = wr_data[`ET_GEN_EN_BIT];
        next_st.legacy = wr_data[`ET_GEN_LEGACY_BIT];
      end
      else if (addr == `ET_INT_CLEAR)
        next_st.status = st.status & ~wr_data[`ET_MAX_TIMERS-1:0];
      else if (addr == `ET_INT_ENABLE)
        next_st.irq_en = wr_data[`ET_MAX_TIMERS-1:0];
      else if (addr == `ET_COUNT_LO)
        next_st.count[31:0] = wr_data;
      else if (addr == `ET_COUNT_HI)
        next_st.count[63:32] = wr_data;
    end
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
      if (wr_en && tmr_hit(addr, i, `ET_TMR_CFG))
      begin
        next_st.cfg[i].level    = wr_data[`ET_CFG_LEVEL_BIT];
        next_st.cfg[i].int_en   = wr_data[`ET_CFG_INTEN_BIT];
        next_st.cfg[i].periodic = (i == 0) && wr_data[`ET_CFG_PERIOD_BIT];
        next_st.cfg[i].wide     = (i == 0) && wr_data[`ET_CFG_WIDE_BIT];
        next_st.cfg[i].route    = wr_data[`ET_CFG_ROUTE_LSB+:5];
        if (wr_data[`ET_CFG_LOAD_BIT])
          next_st.cfg[i].direct_load = 1'b1;
      end
      // Periodic match advances by the last written period
      if (match[i] && st.cfg[i].periodic)
        next_st.cmp[i] = st.cmp[i] + st.period;
      if (cmp_lo_wr[i] || cmp_hi_wr[i])
      begin
        if (i == 0)
        begin
          if (cmp_lo_wr[i])
            next_st.period[31:0] = wr_data;
          else
            next_st.period[63:32] = wr_data;
        end
        // Running periodic timer keeps its match point unless direct load is set
        if (!st.cfg[i].periodic || st.cfg[i].direct_load)
        begin
          if (cmp_lo_wr[i])
            next_st.cmp[i][31:0] = wr_data;
          else
            next_st.cmp[i][63:32] = wr_data;
        end
        next_st.cfg[i].direct_load = 1'b0;
      end
      if (match[i] && st.cfg[i].int_en)
      begin
        next_st.status[i] = 1'b1;
        next_st.pulse[i]  = 1'b1;
      end
    end
    if (rd_en)
    begin
      if (addr == `ET_GEN_CFG)
      begin
        next_st.rd_data[`ET_GEN_EN_BIT]     = st.en;
        next_st.rd_data[`ET_GEN_LEGACY_BIT] = st.legacy;
      end
      else if (addr == `ET_INT_STATUS)
        next_st.rd_data[`ET_MAX_TIMERS-1:0] = st.status;
      else if (addr == `ET_INT_ENABLE)
        next_st.rd_data[`ET_MAX_TIMERS-1:0] = st.irq_en;
      else if (addr == `ET_COUNT_LO)
        next_st.rd_data = st.count[31:0];
      else if (addr == `ET_COUNT_HI)
        next_st.rd_data = st.count[63:32];
      else
      begin
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
          if (tmr_hit(addr, i, `ET_TMR_CFG))
            next_st.rd_data = cfg_word(st.cfg[i], i);
          else if (tmr_hit(addr, i, `ET_TMR_CMP_LO))
            next_st.rd_data = st.cmp[i][31:0];
          else if (i == 0 && tmr_hit(addr, i, `ET_TMR_CMP_HI))
            next_st.rd_data = st.cmp[i][63:32];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  // Level type drives the sticky bit, edge type a one-cycle pulse; lines are OR-shared
  always_comb
  begin
    logic [4:0] line;
    line = 5'h00;
    irq_lines = '0;
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
      line = st.cfg[i].route;
      if (st.legacy && i == 0)
        line = `ET_LEGACY_LINE0;
      else if (st.legacy && i == 1)
        line = `ET_LEGACY_LINE1;
      if (st.cfg[i].level ? st.status[i] : st.pulse[i])
        irq_lines[line] = 1'b1;
    end
  end

  assign irq     = |(st.status & st.irq_en);
  assign rd_data = st.rd_data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  count_step_a: assert property ((st.en && !cnt_wr) |=> st.count == $past(st.count) + 64'h1)
    else $error("counter did not step by one");
  count_halt_a: assert property ((!st.en && !cnt_wr) |=> $stable(st.count))
    else $error("counter moved while disabled");
  periodic_advance_a: assert property ((match[0] && st.cfg[0].periodic && !cmp_lo_wr[0]
    && !cmp_hi_wr[0]) |=> st.cmp[0] == $past(st.cmp[0]) + $past(st.period))
    else $error("periodic comparator did not advance by period");
  period_write_a: assert property ((cmp_lo_wr[0] && st.cfg[0].periodic
    && !st.cfg[0].direct_load) |=> st.period[31:0] == $past(wr_data)
    && st.cmp[0] == $past(st.cmp[0]) + ($past(match[0]) ? $past(st.period) : 64'h0))
    else $error("period write mishandled");
  oneshot_keep_a: assert property ((match[1] && !cmp_lo_wr[1]) |=> $stable(st.cmp[1]))
    else $error("one-shot comparator changed by hardware");
  load_clear_a: assert property ((cmp_lo_wr[0] && st.cfg[0].direct_load)
    |=> !st.cfg[0].direct_load && st.cmp[0][31:0] == $past(wr_data))
    else $error("direct load did not take and clear");
  status_set_a: assert property ((match[0] && st.cfg[0].int_en) |=> st.status[0])
    else $error("match did not set status");
  no_status_a: assert property ((!st.cfg[1].int_en && !st.status[1]
    && !(wr_en && tmr_hit(addr, 1, `ET_TMR_CFG))) |=> !st.status[1])
    else $error("status set without timer enable");
  cap_bits_a: assert property ((rd_en && tmr_hit(addr, 1, `ET_TMR_CFG))
    |=> !rd_data[`ET_CFG_PERCAP_BIT])
    else $error("timer one claims periodic capability");
  cap_zero_a: assert property ((rd_en && tmr_hit(addr, 0, `ET_TMR_CFG))
    |=> rd_data[`ET_CFG_PERCAP_BIT])
    else $error("timer zero hides periodic capability");
  legacy_high_a: assert property ((st.legacy && st.cfg[0].level && st.status[0])
    |-> irq_lines[`ET_LEGACY_LINE0])
    else $error("legacy line not driven high");
  legacy_line_one_a: assert property ((st.legacy && st.cfg[1].level && st.status[1])
    |-> irq_lines[`ET_LEGACY_LINE1])
    else $error("legacy line one not driven high");
  route_select_a: assert property ((!st.legacy && st.cfg[1].level && st.status[1])
    |-> irq_lines[st.cfg[1].route])
    else $error("routed line not driven high");
  edge_pulse_a: assert property ((match[0] && st.cfg[0].int_en && !st.cfg[0].level
    && st.cfg[0].route == 5'h00 && !st.legacy && !wr_en) |=> irq_lines[0])
    else $error("edge type gave no pulse");

  // Status, clear, interrupt output and the enable gate on match
  set_wins_a: assert property ((wr_en && addr == `ET_INT_CLEAR && wr_data[0]
    && match[0] && st.cfg[0].int_en) |=> st.status[0])
    else $error("clear beat a match in the same cycle");
  status_clear_a: assert property ((wr_en && addr == `ET_INT_CLEAR && wr_data[1]
    && !(match[1] && st.cfg[1].int_en)) |=> !st.status[1])
    else $error("status bit not cleared");
  irq_level_a: assert property ((st.status[1] && st.irq_en[1]) |-> irq)
    else $error("irq low with enabled status");
  match_gate_a: assert property (!st.en |-> match == '0)
    else $error("match while overall enable clear");

  // Comparator width and capability
  narrow_match_a: assert property ((st.en && !st.cfg[0].wide
    && st.count[31:0] == st.cmp[0][31:0]) |-> match[0])
    else $error("32-bit compare missed");
  wide_match_a: assert property ((st.en && st.cfg[0].wide && st.count[31:0] == st.cmp[0][31:0]
    && st.count[63:32] != st.cmp[0][63:32]) |-> !match[0])
    else $error("64-bit compare ignored upper word");
  oneshot_only_a: assert property (!st.cfg[1].periodic && !st.cfg[1].wide)
    else $error("timer one left one-shot 32-bit mode");
  narrow_cap_a: assert property ((rd_en && tmr_hit(addr, 1, `ET_TMR_CFG))
    |=> !rd_data[`ET_CFG_SIZECAP_BIT] && !rd_data[`ET_CFG_WIDE_BIT])
    else $error("timer one claims 64-bit width");

  // Register writes and reads
  load_set_a: assert property ((wr_en && tmr_hit(addr, 0, `ET_TMR_CFG)
    && wr_data[`ET_CFG_LOAD_BIT]) |=> st.cfg[0].direct_load)
    else $error("direct load bit not set");
  period_high_a: assert property (cmp_hi_wr[0] |=> st.period[63:32] == $past(wr_data))
    else $error("upper period word not taken");
  count_write_a: assert property ((wr_en && addr == `ET_COUNT_LO)
    |=> st.count[31:0] == $past(wr_data))
    else $error("counter write lost");
  cmp_read_a: assert property ((rd_en && tmr_hit(addr, 0, `ET_TMR_CMP_LO))
    |=> rd_data == $past(st.cmp[0][31:0]))
    else $error("comparator read not next match");
  gen_read_a: assert property ((rd_en && addr == `ET_GEN_CFG)
    |=> rd_data[`ET_GEN_EN_BIT] == $past(st.en))
    else $error("overall enable read wrong");
  read_idle_a: assert property (!rd_en |=> rd_data == 32'h0000_0000)
    else $error("read data stands past its cycle");

  periodic_cov: cover property (match[0] && st.cfg[0].periodic ##1 st.status[0]);
  oneshot_cov: cover property (match[1] && st.cfg[1].int_en);
  load_cov: cover property (cmp_lo_wr[0] && st.cfg[0].direct_load && st.cfg[0].periodic);
  irq_cov: cover property (irq ##1 !irq);
  legacy_cov: cover property (st.legacy && irq_lines[`ET_LEGACY_LINE1]);
endmodule

/* File: testbench/irq_controller_model.sv */
// Interrupt controller model that counts requests on one timer line
`timescale 1ns/1ps
module irq_controller_model
  import event_timer_pkg::*;
#(
  parameter int LINE = 0
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] lines,
  output logic [7:0]       req_count
);
  logic prev;
  // Requests are taken as active high rising edges
  always_ff @(posedge clk)
  begin
    prev <= lines[LINE];
    if (!rst_n)
      req_count <= 8'h00;
    else if (lines[LINE] && !prev)
      req_count <= req_count + 8'h01;
  end
endmodule

/* File: testbench/periodic_event_timer_comparator_tb.sv */
// Self-checking bench of the event timer comparator block
`timescale 1ns/1ps
module periodic_event_timer_comparator_tb
  import event_timer_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic [11:0] addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        irq;
  logic [31:0] irq_lines;
  logic [7:0]  req_count;
  int          n_fail;
  int          checks;
  // Rows: write flag, address, write data or expected read data
  localparam logic [44:0] ROWS [8] = '{
    {1'b0, 12'h010, 32'h0}, {1'b0, 12'h100, 32'h30}, {1'b0, 12'h120, 32'h0},
    {1'b1, 12'h120, 32'h108}, {1'b0, 12'h120, 32'h0}, {1'b1, 12'h000, 32'hFFFF},
    {1'b0, 12'h000, 32'h0}, {1'b0, 12'h020, 32'h0}};

  periodic_event_timer_comparator uut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .irq(irq), .irq_lines(irq_lines));
  irq_controller_model #(.LINE(0)) ctrl (.clk(clk), .rst_n(rst_n),
    .lines(irq_lines), .req_count(req_count));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(name, exp, rd_data);
  endtask

  // Waits for irq (sel < 0) or for one request line
  task automatic wait_hi(input int sel);
    for (int i = 0; i < 1000; i++)
    begin
      @(posedge clk);
      #1;
      if ((sel < 0) ? irq : irq_lines[sel])
        return;
    end
    n_fail++;
    $display("ERROR wait expected 1 seen 0");
    end_of_test();
  endtask

  initial
  begin
    rst_n = 1'b0;
    addr = 12'h000;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i])
      if (ROWS[i][44])
        wr(ROWS[i][43:32], ROWS[i][31:0]);
      else
        rd(ROWS[i][43:32], ROWS[i][31:0], $sformatf("row %0d", i));
    wr(12'h0F0, 32'h5);
    rd(12'h0F0, 32'h5, "halted count");
    wr(12'h010, 32'h1);
    repeat (10) @(posedge clk);
    wr(12'h010, 32'h0);
    rd(12'h0F0, 32'h11, "count low");
    rd(12'h0F4, 32'h0, "count high");
    // One-shot timer 1, level type on line 3
    wr(12'h0F0, 32'h0);
    wr(12'h010, 32'h1);
    wr(12'h120, 32'h606);
    wr(12'h028, 32'h2);
    wr(12'h128, 32'h20);
    wait_hi(-1);
    chk("line 3", 32'h1, {31'h0, irq_lines[3]});
    rd(12'h020, 32'h2, "status");
    rd(12'h128, 32'h20, "one-shot cmp");
    wr(12'h028, 32'h0);
    #1;
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(12'h024, 32'h2);
    rd(12'h020, 32'h0, "cleared status");
    chk("line 3 low", 32'h0, {31'h0, irq_lines[3]});
    // Periodic timer 0, edge type on line 0, restarted with direct load
    wr(12'h010, 32'h0);
    wr(12'h0F0, 32'h0);
    wr(12'h100, 32'h4C);
    wr(12'h108, 32'h40);
    rd(12'h100, 32'h3C, "direct load cleared");
    wr(12'h010, 32'h1);
    wait_hi(0);
    @(posedge clk);
    #1;
    chk("edge pulse", 32'h0, {31'h0, irq_lines[0]});
    rd(12'h108, 32'h80, "next match");
    wr(12'h108, 32'h10);
    rd(12'h108, 32'h80, "match kept");
    wait_hi(0);
    rd(12'h108, 32'h90, "new period");
    chk("requests", 32'h2, {24'h0, req_count});
    // Legacy routing moves level timer one onto line 8
    wr(12'h010, 32'h3);
    #1;
    chk("legacy line 8", 32'h1, {31'h0, irq_lines[8]});
    rd(12'h010, 32'h3, "gen cfg");
    @(posedge clk);
    #1;
    chk("read idle", 32'h0, rd_data);
    // Reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("reset irq", 32'h0, {31'h0, irq});
    chk("reset lines", 32'h0, irq_lines);
    rd(12'h020, 32'h0, "reset status");
    rd(12'h0F0, 32'h0, "reset count");
    chk("reset requests", 32'h0, {24'h0, req_count});
    end_of_test();
  end
endmodule
